// *** pkg/crcu_defines.vh ***
// Constants for the CRC instruction unit.
// Assumes inclusion by bare name from the design files.
`ifndef CRCU_DEFINES_VH
`define CRCU_DEFINES_VH
// ----------------------------------------------------------------------
// Instruction encoding
// ----------------------------------------------------------------------
`define CRCU_MAJOR_OPCODE   6'h1f
`define CRCU_FUNC_CODE      6'h0f
`define CRCU_ZERO_FIELD     5'h00
`define CRCU_SEL_IEEE       3'h0
`define CRCU_SEL_CASTAG     3'h1
`define CRCU_SIZE_BYTE      2'h0
`define CRCU_SIZE_HALF      2'h1
`define CRCU_SIZE_WORD      2'h2
`define CRCU_SIZE_DWORD     2'h3
// ----------------------------------------------------------------------
// Polynomials
// ----------------------------------------------------------------------
`define CRCU_POLY_IEEE      32'hedb88320
`define CRCU_POLY_CASTAG    32'h82f63b78
`define CRCU_CRC_MASK       32'hffffffff
// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define CRCU_REG_STATUS     2'h0
`define CRCU_REG_ENABLE     2'h1
`define CRCU_REG_CLEAR      2'h2
`define CRCU_REG_CONFIG     2'h3
`define CRCU_ENABLE_RESET   2'h0
`define CRCU_CONFIG_RESET   2'h3
`define CRCU_EV_DONE        0
`define CRCU_EV_TRAP        1
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CRCU_LATENCY        2
`endif

// *** hdl/crcu_byte_step.v ***
// One byte of reflected CRC: eight shift and conditional XOR steps.
// Assumes purely combinational use inside the datapath.
`timescale 1ns/1ns
`default_nettype none
module crcu_byte_step (
  input  wire [31:0] crc_in,
  input  wire [7:0]  data_in,
  input  wire [31:0] poly,
  output reg  [31:0] crc_out
);
  integer i;
  always @* begin
    crc_out = crc_in ^ {24'h000000, data_in};
    for (i = 0; i < 8; i = i + 1) begin
      if (crc_out[0]) begin
        crc_out = (crc_out >> 1) ^ poly;
      end else begin
        crc_out = crc_out >> 1;
      end
    end
  end
endmodule // crcu_byte_step
`default_nettype wire

// *** hdl/crcu_avmm_regs.v ***
// Avalon-MM register slave with sticky events, enable, clear and config.
// Assumes a master on the same clock; answers after one cycle of waitrequest high.
`timescale 1ns/1ns
`default_nettype none
`include "crcu_defines.vh"
module crcu_avmm_regs (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire [1:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire [1:0]  event_set,
  output wire        irq,
  output reg         crc_present_flag,
  output reg         ops64_enable
);
  reg  [1:0] status;
  reg  [1:0] enable;
  reg        ack;
  wire       clear_hit;
  // ----------------------------------------------------------------------
  // Handshake: one wait cycle, then a one-cycle accept.
  // ----------------------------------------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign clear_hit = avs_write & ack & (avs_address == `CRCU_REG_CLEAR);
  assign irq = |(status & enable);
  always @(posedge clk) begin
    if (sys_rst) begin
      ack <= 1'b0;
      status <= 2'h0;
      enable <= `CRCU_ENABLE_RESET;
      {ops64_enable, crc_present_flag} <= `CRCU_CONFIG_RESET;
      avs_readdata <= 32'h00000000;
    end else begin
      ack <= (avs_read | avs_write) & ~ack;
      // Sets win over a clear in the same cycle.
      status <= (status & ~(clear_hit ? avs_writedata[1:0] : 2'h0)) | event_set;
      if (avs_write & ack) begin
        if (avs_address == `CRCU_REG_ENABLE) begin
          enable <= avs_writedata[1:0];
        end
        if (avs_address == `CRCU_REG_CONFIG) begin
          crc_present_flag <= avs_writedata[0];
          ops64_enable <= avs_writedata[1];
        end
      end
      if (avs_read & ~ack) begin
        case (avs_address)
          `CRCU_REG_STATUS: avs_readdata <= {30'h00000000, status};
          `CRCU_REG_ENABLE: avs_readdata <= {30'h00000000, enable};
          `CRCU_REG_CONFIG: avs_readdata <= {30'h00000000, ops64_enable, crc_present_flag};
          default:          avs_readdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule // crcu_avmm_regs
`default_nettype wire

// *** hdl/crcu_top.v ***
// Execution unit for the cumulative CRC-32 instructions.
// Assumes the pipeline holds operands for the issue cycle only.
//
// Contract
// - Decode opcode, function, zero field, polynomial select.
// - Size field picks one, two, four, eight bytes.
// - Feature flag clear traps, destination unchanged.
// - Eight-byte element traps unless 64-bit enabled.
// - Running CRC low word XOR zero-extended element.
// - Shift right, XOR polynomial when bit zero set.
// - Sign-extend result, write back to CRC register.
// - No trap depends on operand values.
// - Element bit zero is top coefficient.
// - Polynomials are 32-bit reflected, top bit implied.
// - Wide element equals narrow elements in sequence.
`timescale 1ns/1ns
`default_nettype none
`include "crcu_defines.vh"
module crcu_top (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        issue_valid,
  input  wire [31:0] instr_word,
  input  wire [63:0] running_crc_operand,
  input  wire [63:0] message_operand,
  input  wire [4:0]  dest_index,
  output reg         result_valid,
  output reg  [63:0] result_data,
  output reg  [4:0]  result_index,
  output reg         result_write,
  output reg         reserved_trap,
  output wire        is_crc_op,
  input  wire [1:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output wire        irq
);
  wire        crc_present_flag;
  wire        ops64_enable;
  wire [1:0]  element_size_field;
  wire [2:0]  poly_sel;
  wire [31:0] poly;
  wire        trap_now;
  wire [31:0] stage [0:8];
  reg  [31:0] next_crc;
  reg         s1_valid;
  reg         s1_trap;
  reg  [31:0] s1_crc;
  reg  [4:0]  s1_index;
  reg  [1:0]  events;
  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  assign element_size_field = instr_word[7:6];
  assign poly_sel = instr_word[10:8];
  assign is_crc_op = (instr_word[31:26] == `CRCU_MAJOR_OPCODE) &
                     (instr_word[5:0] == `CRCU_FUNC_CODE) &
                     (instr_word[15:11] == `CRCU_ZERO_FIELD) &
                     ((poly_sel == `CRCU_SEL_IEEE) | (poly_sel == `CRCU_SEL_CASTAG));
  assign poly = (poly_sel == `CRCU_SEL_CASTAG) ? `CRCU_POLY_CASTAG : `CRCU_POLY_IEEE;
  // Traps come only from configuration and size, never from data.
  assign trap_now = ~crc_present_flag |
                    ((element_size_field == `CRCU_SIZE_DWORD) & ~ops64_enable);
  // ----------------------------------------------------------------------
  // Datapath: a byte chain, each byte LSB first.
  // ----------------------------------------------------------------------
  assign stage[0] = running_crc_operand[31:0] & `CRCU_CRC_MASK;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_byte
      crcu_byte_step u_step (
        .crc_in  (stage[g]),
        .data_in (message_operand[8*g+7:8*g]),
        .poly    (poly),
        .crc_out (stage[g+1])
      );
    end
  endgenerate
  always @* begin
    case (element_size_field)
      `CRCU_SIZE_BYTE:  next_crc = stage[1];
      `CRCU_SIZE_HALF:  next_crc = stage[2];
      `CRCU_SIZE_WORD:  next_crc = stage[4];
      `CRCU_SIZE_DWORD: next_crc = stage[8];
      default:          next_crc = stage[1];
    endcase
  end
  // ----------------------------------------------------------------------
  // Two-stage pipeline: fixed latency of two cycles.
  // ----------------------------------------------------------------------
  always @(posedge clk) begin
    if (sys_rst) begin
      s1_valid <= 1'b0;
      s1_trap <= 1'b0;
      s1_crc <= 32'h00000000;
      s1_index <= 5'h00;
      result_valid <= 1'b0;
      result_data <= 64'h0000000000000000;
      result_index <= 5'h00;
      result_write <= 1'b0;
      reserved_trap <= 1'b0;
      events <= 2'h0;
    end else begin
      s1_valid <= issue_valid & is_crc_op;
      s1_trap <= trap_now;
      s1_crc <= next_crc;
      s1_index <= dest_index;
      result_valid <= s1_valid;
      result_write <= s1_valid & ~s1_trap;
      reserved_trap <= s1_valid & s1_trap;
      result_index <= s1_index;
      result_data <= {{32{s1_crc[31]}}, s1_crc};
      events <= 2'h0;
      events[`CRCU_EV_DONE] <= s1_valid & ~s1_trap;
      events[`CRCU_EV_TRAP] <= s1_valid & s1_trap;
    end
  end
  // ----------------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------------
  crcu_avmm_regs u_regs (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .avs_address      (avs_address),
    .avs_read         (avs_read),
    .avs_write        (avs_write),
    .avs_writedata    (avs_writedata),
    .avs_readdata     (avs_readdata),
    .avs_waitrequest  (avs_waitrequest),
    .event_set        (events),
    .irq              (irq),
    .crc_present_flag (crc_present_flag),
    .ops64_enable     (ops64_enable)
  );
endmodule // crcu_top
`default_nettype wire

// *** tb/crcu_assertions.sv ***
// Concurrent checks on the ports of the CRC instruction unit.
// Assumes one clock and the synchronous reset of crcu_top.
`timescale 1ns/1ns
`default_nettype none
module crcu_checker (
  input wire        clk,
  input wire        sys_rst,
  input wire        issue_valid,
  input wire [31:0] instr_word,
  input wire [4:0]  dest_index,
  input wire        result_valid,
  input wire [63:0] result_data,
  input wire [4:0]  result_index,
  input wire        result_write,
  input wire        reserved_trap,
  input wire        is_crc_op,
  input wire        avs_read,
  input wire        avs_write,
  input wire        avs_waitrequest
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_fixed_latency: assert property (issue_valid && is_crc_op |-> ##2 result_valid)
    else $error("result not two cycles after issue");
  a_valid_cause: assert property (result_valid |-> $past(issue_valid && is_crc_op, 2))
    else $error("result without an accepted issue");
  a_one_outcome: assert property (result_valid |-> result_write ^ reserved_trap)
    else $error("result must either write or trap");
  a_no_stray: assert property (!result_valid |-> !result_write && !reserved_trap)
    else $error("write or trap outside a result");
  a_index_copy: assert property (issue_valid && is_crc_op |->
    ##2 result_index == $past(dest_index, 2))
    else $error("result index differs from destination");
  a_decode_match: assert property (is_crc_op == (instr_word[31:26] == 6'h1f &&
    instr_word[15:9] == 7'h00 && instr_word[5:0] == 6'h0f))
    else $error("decode disagrees with encoding");
  a_sign_extend: assert property (result_write |-> result_data[63:32] == {32{result_data[31]}})
    else $error("result not sign extended");
  a_bus_answer: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus answer not in second cycle");
endmodule // crcu_checker
bind crcu_top crcu_checker crcu_checker_i (.clk(clk), .sys_rst(sys_rst),
  .issue_valid(issue_valid), .instr_word(instr_word), .dest_index(dest_index),
  .result_valid(result_valid), .result_data(result_data), .result_index(result_index),
  .result_write(result_write), .reserved_trap(reserved_trap), .is_crc_op(is_crc_op),
  .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest));
`default_nettype wire

// *** tb/crcu_pipe_model.sv ***
// Pipeline model that issues instructions to the CRC unit.
// Assumes each call starts just after a rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module crcu_pipe_model (
  input  wire         clk,
  output logic        issue_valid = 1'b0,
  output logic [31:0] instr_word = 32'h0,
  output logic [63:0] running_crc_operand = 64'h0,
  output logic [63:0] message_operand = 64'h0,
  output logic [4:0]  dest_index = 5'h0
);
  // Idle instruction and message operands are inverted so stale values are never taken for new ones.
  task automatic send(input [31:0] iw, input [31:0] crc, input [63:0] msg, input [4:0] ix,
                      input bit last);
    issue_valid <= 1'b1;
    instr_word <= iw;
    running_crc_operand <= {~crc, crc};
    message_operand <= msg;
    dest_index <= ix;
    @(posedge clk);
    if (last) begin
      issue_valid <= 1'b0;
      instr_word <= ~iw;
      message_operand <= ~msg;
      @(posedge clk);
    end
  endtask
endmodule // crcu_pipe_model
`default_nettype wire

// *** tb/crcu_top_test.sv ***
// Self-checking bench for the CRC instruction unit.
// Assumes the design, the pipeline model and the checker are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "crcu_defines.vh"
module crcu_top_test;
  logic        clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0;
  logic [1:0]  avs_address = 0, cfg = 2'h3;
  logic [31:0] avs_writedata = 0, rd, s = 32'hdfb7, c;
  logic [63:0] last_res;
  logic [70:0] q[$];
  wire         iv, rv, rw, tp, ic, wr, irq;
  wire  [31:0] iw, ard;
  wire  [63:0] rc, mo, rdt;
  wire  [4:0]  di, ri;
  integer      fail_count = 0, samples_checked = 0, cyc = 0, k;
  always #20 clk = ~clk;
  crcu_pipe_model crcu_pipe_model_i (.clk(clk), .issue_valid(iv), .instr_word(iw),
    .running_crc_operand(rc), .message_operand(mo), .dest_index(di));
  crcu_top crcu_top_i (.clk(clk), .sys_rst(sys_rst), .issue_valid(iv), .instr_word(iw),
    .running_crc_operand(rc), .message_operand(mo), .dest_index(di), .result_valid(rv),
    .result_data(rdt), .result_index(ri), .result_write(rw), .reserved_trap(tp),
    .is_crc_op(ic), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(ard), .avs_waitrequest(wr), .irq(irq));
  function automatic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  function automatic [31:0] mcrc(input [31:0] v, input [63:0] m, input int n, input [31:0] p);
    logic [63:0] w;
    w = {32'h0, v} ^ (m & ~(64'hffffffffffffffff << (n * 8)));
    for (int i = 0; i < n * 8; i++)
      w = w[0] ? (w >> 1) ^ p : w >> 1;
    return w[31:0];
  endfunction
  task automatic chk_res(input [70:0] got, input [70:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t result %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_reg(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d failed %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic av(input bit w, input [1:0] a, input [31:0] d, output [31:0] r);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk); while (wr !== 1'b0);
    r = ard;
    avs_read <= 0;
    avs_write <= 0;
    @(posedge clk);
  endtask
  task automatic op(input [2:0] sel, input [1:0] es, input [31:0] v, input [63:0] m, input bit l);
    logic [31:0] f, r;
    logic        tr;
    f = rnd();
    tr = !cfg[0] || (es == 3 && !cfg[1]);
    r = mcrc(v, m, 1 << es, sel[0] ? `CRCU_POLY_CASTAG : `CRCU_POLY_IEEE);
    q.push_back({tr, !tr, f[4:0], tr ? 64'h0 : {{32{r[31]}}, r}});
    crcu_pipe_model_i.send({`CRCU_MAJOR_OPCODE, f[15:6], 5'h0, sel, es, `CRCU_FUNC_CODE},
      v, m, f[4:0], l);
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!sys_rst && rv === 1'b1) begin
      last_res <= rdt;
      chk_reg(q.size() > 0, 1);
      if (q.size() > 0)
        chk_res({tp, rw, ri, rw ? rdt : 64'h0}, q.pop_front());
    end else if (!sys_rst && rv !== 1'b0) begin
      chk_reg(rv, 0);
    end
    if (cyc == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 0;
    @(posedge clk);
    av(0, `CRCU_REG_ENABLE, 0, rd);
    chk_reg(rd, `CRCU_ENABLE_RESET);
    av(0, `CRCU_REG_CONFIG, 0, rd);
    chk_reg(rd, `CRCU_CONFIG_RESET);
    for (k = 0; k < 16; k++)
      op(k[0], k[2:1], rnd(), {rnd(), rnd()}, k == 15);
    crcu_pipe_model_i.send({6'h1f, 10'h0, 5'h0, 3'h2, 2'h0, 6'h0f}, 0, 0, 0, 0);
    crcu_pipe_model_i.send({6'h1f, 10'h0, 5'h1, 3'h0, 2'h0, 6'h0f}, 0, 0, 0, 1);
    repeat (4) @(posedge clk);
    av(0, `CRCU_REG_STATUS, 0, rd);
    chk_reg(rd, 32'h1);
    chk_reg(irq, 0);
    av(1, `CRCU_REG_CLEAR, 3, rd);
    av(0, `CRCU_REG_CLEAR, 0, rd);
    chk_reg(rd, 0);
    av(0, `CRCU_REG_STATUS, 0, rd);
    chk_reg(rd, 0);
    c = 32'hffffffff;
    rd = rnd();
    op(0, 2, c, {32'h0, rd}, 1);
    for (k = 0; k < 4; k++) begin
      op(0, 0, c, {32'h0, rd >> (8 * k)}, 1);
      repeat (3) @(posedge clk);
      c = last_res[31:0];
    end
    chk_res(c, mcrc(32'hffffffff, {32'h0, rd}, 4, `CRCU_POLY_IEEE));
    av(1, `CRCU_REG_ENABLE, 2, rd);
    av(1, `CRCU_REG_CONFIG, 1, rd);
    cfg = 1;
    op(1, 3, rnd(), {rnd(), rnd()}, 0);
    op(1, 2, rnd(), {rnd(), rnd()}, 1);
    av(1, `CRCU_REG_CONFIG, 0, rd);
    cfg = 0;
    op(1, 0, rnd(), rnd(), 1);
    repeat (4) @(posedge clk);
    chk_reg(irq, 1);
    av(0, `CRCU_REG_STATUS, 0, rd);
    chk_reg(rd & 2, 2);
    av(1, `CRCU_REG_CLEAR, 3, rd);
    chk_reg(irq, 0);
    chk_reg(q.size(), 0);
    stop_test();
  end
endmodule // crcu_top_test
`default_nettype wire
